/* src/fsss_pkg.sv */
// Package for the fuse shadow start-up sequencer: field layout,
// reset values and timing counts.
// Assumes a 50 MHz system clock; all other rates are enables.
package fsss_pkg;

  // ----------------
  // Clock and time base
  // ----------------
  localparam int CLK_HZ = 50_000_000;       // System clock rate
  localparam int TICK_HZ = 32_000;          // Start-up time base rate
  localparam int TICK_DIV = CLK_HZ / TICK_HZ; // Cycles per 32 kHz tick

  // ----------------
  // Slot and power-good timing, in microseconds
  // ----------------
  localparam int SLOT_SHORT_US = 500;       // Slot delay, select 0
  localparam int SLOT_LONG_US = 2000;       // Slot delay, select 1
  localparam int PGOOD_US = 2000;           // Power-good release delay
  // Ticks of 32 kHz, least times rounded up
  localparam int SLOT_SHORT_TK = (SLOT_SHORT_US * TICK_HZ + 999_999)
                                 / 1_000_000;
  localparam int SLOT_LONG_TK = (SLOT_LONG_US * TICK_HZ + 999_999)
                                / 1_000_000;
  localparam int PGOOD_TK = (PGOOD_US * TICK_HZ + 999_999) / 1_000_000;

  // ----------------
  // Turn-on pin timing, in microseconds, counted in ticks
  // ----------------
  localparam int OFF_HOLD_US = 4_000_000;   // Long press turns off
  localparam int OFF_HOLD_TK = (OFF_HOLD_US / 1000) * TICK_HZ / 1000;
  localparam int DBNC1_US = 31_250;         // Debounce code 01
  localparam int DBNC2_US = 125_000;        // Debounce code 10
  localparam int DBNC3_US = 750_000;        // Debounce code 11
  localparam int DBNC1_TK = (DBNC1_US * 32 + 999) / 1000;
  localparam int DBNC2_TK = (DBNC2_US * 32 + 999) / 1000;
  localparam int DBNC3_TK = (DBNC3_US * 32 + 999) / 1000;

  // ----------------
  // Soft-start step timing, in nanoseconds
  // ----------------
  localparam int STEP_FAST_NS = 2000;       // Step period, select 0
  localparam int STEP_SLOW_NS = 4000;       // Step period, select 1
  localparam int CLK_NS = 20;
  localparam int STEP_FAST_CY = STEP_FAST_NS / CLK_NS;
  localparam int STEP_SLOW_CY = STEP_SLOW_NS / CLK_NS;
  localparam int STEP_MV = 25;              // Output step size

  // ----------------
  // Regulator set and slot code widths
  // ----------------
  localparam int N_WIDE = 6;                // Bucks, boost, 3.3 V, card
  localparam int N_LIN = 4;                 // Linear regulators
  localparam int N_REG = N_WIDE + N_LIN;
  localparam int SLOT_W_WIDE = 3;
  localparam int SLOT_W_LIN = 4;
  localparam int VOLT_W = 5;                // Voltage code width

  // ----------------
  // Bus address configuration layout
  // ----------------
  localparam int ADDR_LOW_LSB = 0;          // Low three address bits
  localparam int KEEP_FACTORY_BIT = 7;      // Keep default address
  localparam logic [6:0] FACTORY_ADDR = 7'h08;
  localparam logic [7:0] BUS_ADDR_RST = 8'h00;

  // ----------------
  // Sequencer states
  // ----------------
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_LOAD  = 3'b001,
    ST_COPY  = 3'b010,
    ST_SLOTS = 3'b011,
    ST_PGOOD = 3'b100,
    ST_ON    = 3'b101
  } fsss_state_type;

endpackage

/* src/fsss_ramp.sv */
// One buck soft-start ramp: moves the output code one step at a
// time towards the target.
// Assumes a target code from the live register and a run enable.
module fsss_ramp #(
  parameter int VW = fsss_pkg::VOLT_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic rate_sel,
  input wire logic [VW-1:0] target,
  // Ramped code
  output logic [VW-1:0] level_r
);

  // ----------------------------------------------------------------
  // Step timer
  // ----------------------------------------------------------------
  logic [7:0] cnt_r; // Cycles since last step
  logic [7:0] limit; // Period for the chosen rate
  assign limit = rate_sel ? 8'(fsss_pkg::STEP_SLOW_CY - 1)
                          : 8'(fsss_pkg::STEP_FAST_CY - 1);

  // Step one code (one step of 25 mV) per period
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      level_r <= '0;
    end else if (!run) begin
      // Off rails fall to zero so the next start ramps again
      cnt_r <= 8'h00;
      level_r <= '0;
    end else if (cnt_r >= limit) begin
      cnt_r <= 8'h00;
      if (level_r < target) begin
        level_r <= level_r + 1'b1; // R13
      end else if (level_r > target) begin
        level_r <= level_r - 1'b1; // R13
      end
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule

/* src/fsss_top.sv */
// Start-up sequencer: fuse load, shadow to live copy, slotted
// regulator enables, power-good release, turn-on pin handling and
// bus address selection.
// Assumes fuse words arrive on plain inputs and that the serial-bus
// slave outside presents register writes as one-cycle strobes.
//
// Contract
// R1: Power up copies fuses, shadows, then live
// R2: Shadow writes do nothing; live writes apply
// R3: Three-bit codes for switchers, four for linear
// R4: Zero code stays off; software enables later
// R5: Code n enables n slot delays after turn-on
// R6: Slot delay 500 us or 2000 us
// R7: Power good high 2 ms after last slot
// R8: Level mode: pin high on, low off
// R9: Edge mode: falling on, 4 s low off
// R10: Bus address is 0x08 to 0x0F
// R11: New address applies once write completes
// R12: Host sets bit 7 to keep 0x08
// R13: Soft-start 25 mV steps, 2 or 4 us
// R14: Cold start loads fuses above undervoltage
// R15: Every turn-on reloads shadows from fuses
// R16: Pin level flag follows pin, undebounced
// R17: Turn-on goes to On, sets irq, sense
// R18: Edge-mode debounce 0, 31.25, 125, 750 ms
// R19: Slot timing counted from 32 kHz base
// R20: Equal slot codes enable together, one counter
// R21: Slot counter restarts on turn-on, then stops
module fsss_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Supply and turn-on pin
  input wire logic vin_above_uv,
  input wire logic turnon_pin,
  // Fuse contents
  input wire logic [fsss_pkg::N_WIDE*3-1:0] fuse_wide_slots,
  input wire logic [fsss_pkg::N_LIN*4-1:0] fuse_lin_slots,
  input wire logic [4:0] fuse_buck1_volt,
  input wire logic [7:0] fuse_bus_addr,
  input wire logic fuse_slot_delay_sel,
  input wire logic fuse_pin_style,
  input wire logic [1:0] fuse_debounce_sel,
  input wire logic fuse_softstart_sel,
  // Register writes from the serial-bus slave
  input wire logic shadow_volt_we,
  input wire logic live_volt_we,
  input wire logic [4:0] volt_wdata,
  input wire logic bus_addr_we,
  input wire logic [7:0] bus_addr_wdata,
  input wire logic enable_we,
  input wire logic [fsss_pkg::N_REG-1:0] enable_wdata,
  input wire logic irq_clear,
  // Outputs
  output logic [fsss_pkg::N_REG-1:0] reg_enable_r,
  output logic [4:0] buck1_voltage_live_r,
  output logic [4:0] buck1_ramp_level,
  output logic power_good_out_r,
  output logic turnon_pin_irq_r,
  output logic turn_on_pin_level_flag,
  output logic [6:0] bus_slave_addr_r,
  output logic [7:0] bus_address_config_r,
  output logic seq_done_r
);

  // ----------------
  // Pin synchronisers
  // ----------------
  logic [1:0] pin_sync_r; // Two stages for the turn-on pin
  logic [1:0] uv_sync_r;  // Two stages for the supply comparator
  logic pin_prev_r;       // Previous synchronised pin
  logic pin_s;
  logic uv_ok;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync_r <= 2'h0;
      uv_sync_r <= 2'h0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], turnon_pin};
      uv_sync_r <= {uv_sync_r[0], vin_above_uv};
      pin_prev_r <= pin_sync_r[1];
    end
  end
  assign pin_s = pin_sync_r[1];
  assign uv_ok = uv_sync_r[1];
  // Only the synchronised level is exposed, no filtering
  assign turn_on_pin_level_flag = pin_s; // R16

  // ----------------
  // 32 kHz tick from the system clock
  // ----------------
  logic [10:0] div_r; // Divider count
  logic tick;         // One cycle per 32 kHz period
  assign tick = (div_r == 11'(fsss_pkg::TICK_DIV - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r <= 11'h000;
    end else if (tick) begin
      div_r <= 11'h000;
    end else begin
      div_r <= div_r + 11'h001; // R19
    end
  end

  // ----------------
  // Shadow configuration registers
  // ----------------
  logic [fsss_pkg::N_WIDE*3-1:0] sh_wide_r;
  logic [fsss_pkg::N_LIN*4-1:0] sh_lin_r;
  logic [4:0] sh_volt_r;          // buck1_voltage_shadow
  logic sh_delay_sel_r;           // slot_delay_select
  logic sh_style_r;               // turnon_pin_style
  logic [1:0] sh_dbnc_r;          // turnon_debounce_sel
  logic sh_ss_r;                  // softstart_rate_sel
  fsss_pkg::fsss_state_type st_r; // Sequencer state
  logic load_now;                 // Fuse load this cycle
  assign load_now = (st_r == fsss_pkg::ST_LOAD);

  // Reloaded on every turn-on; software writes only the voltage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_wide_r <= '0;
      sh_lin_r <= '0;
      sh_volt_r <= 5'h00;
      sh_delay_sel_r <= 1'b0;
      sh_style_r <= 1'b0;
      sh_dbnc_r <= 2'h0;
      sh_ss_r <= 1'b0;
    end else if (load_now) begin
      sh_wide_r <= fuse_wide_slots; // R1 R15 R3
      sh_lin_r <= fuse_lin_slots;   // R3
      sh_volt_r <= fuse_buck1_volt; // R1
      sh_delay_sel_r <= fuse_slot_delay_sel;
      sh_style_r <= fuse_pin_style;
      sh_dbnc_r <= fuse_debounce_sel;
      sh_ss_r <= fuse_softstart_sel;
    end else if (shadow_volt_we) begin
      sh_volt_r <= volt_wdata; // R2
    end
  end

  // ----------------------------------------------------------------
  // Turn-on pin interpretation
  // ----------------------------------------------------------------
  logic [24:0] pin_cnt_r; // Debounce or long-press count in ticks
  logic [24:0] dbnc_lim;
  logic on_req;           // Turn-on request
  logic off_req;          // Turn-off request
  logic is_on;
  always_comb begin
    unique case (sh_dbnc_r)
      2'h0: dbnc_lim = 25'h0;
      2'h1: dbnc_lim = 25'(fsss_pkg::DBNC1_TK); // R18
      2'h2: dbnc_lim = 25'(fsss_pkg::DBNC2_TK); // R18
      2'h3: dbnc_lim = 25'(fsss_pkg::DBNC3_TK); // R18
    endcase
  end
  // Counts ticks while the pin stays low, in either mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_cnt_r <= 25'h0;
    end else if (pin_s) begin
      pin_cnt_r <= 25'h0;
    end else if (tick && pin_cnt_r != 25'h1ffffff) begin
      pin_cnt_r <= pin_cnt_r + 25'h1;
    end
  end
  assign is_on = (st_r != fsss_pkg::ST_OFF);
  always_comb begin
    if (!sh_style_r) begin
      on_req = pin_s && !is_on;  // R8
      off_req = !pin_s && is_on; // R8
    end else begin
      // Zero debounce takes the falling edge itself
      on_req = !is_on && !pin_s &&
               ((dbnc_lim == 25'h0) ? pin_prev_r
                : (tick && pin_cnt_r == dbnc_lim - 25'h1)); // R9
      off_req = is_on && !pin_s &&
                pin_cnt_r >= 25'(fsss_pkg::OFF_HOLD_TK); // R9
    end
  end

  // ----------------------------------------------------------------
  // Slot sequencer
  // ----------------------------------------------------------------
  logic [3:0] slot_r;     // Current slot number
  logic [6:0] tk_r;       // Ticks inside current slot
  logic [3:0] last_slot;  // Highest programmed slot
  logic [6:0] slot_lim;
  logic turn_on;
  assign turn_on = on_req && uv_ok; // R14 R17
  assign slot_lim = sh_delay_sel_r ? 7'(fsss_pkg::SLOT_LONG_TK - 1)
                                   : 7'(fsss_pkg::SLOT_SHORT_TK - 1); // R6

  // Slot code of regulator i, zero-extended to four bits
  function automatic logic [3:0] code_of(
    input logic [fsss_pkg::N_WIDE*3-1:0] w,
    input logic [fsss_pkg::N_LIN*4-1:0] l, input int i);
    if (i < fsss_pkg::N_WIDE) return {1'b0, w[i*3 +: 3]};
    return l[(i-fsss_pkg::N_WIDE)*4 +: 4];
  endfunction

  always_comb begin
    last_slot = 4'h0;
    for (int i = 0; i < fsss_pkg::N_REG; i++) begin
      if (code_of(sh_wide_r, sh_lin_r, i) > last_slot)
        last_slot = code_of(sh_wide_r, sh_lin_r, i); // R7
    end
  end

  // State moves: load, copy, slots, power-good wait, on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= fsss_pkg::ST_OFF;
      slot_r <= 4'h0;
      tk_r <= 7'h00;
    end else if (off_req || !uv_ok) begin
      st_r <= fsss_pkg::ST_OFF; // R8 R9
    end else begin
      unique case (st_r)
        fsss_pkg::ST_OFF: if (turn_on) st_r <= fsss_pkg::ST_LOAD;
        fsss_pkg::ST_LOAD: st_r <= fsss_pkg::ST_COPY; // R15
        fsss_pkg::ST_COPY: begin
          st_r <= fsss_pkg::ST_SLOTS;
          slot_r <= 4'h0; // R21
          tk_r <= 7'h00;
        end
        fsss_pkg::ST_SLOTS: if (slot_r == last_slot) begin
          st_r <= fsss_pkg::ST_PGOOD; // R7
          tk_r <= 7'h00;
        end else if (tick) begin
          if (tk_r == slot_lim) begin
            tk_r <= 7'h00;
            slot_r <= slot_r + 4'h1; // R5 R20
          end else begin
            tk_r <= tk_r + 7'h01;
          end
        end
        fsss_pkg::ST_PGOOD: if (tick) begin
          if (tk_r == 7'(fsss_pkg::PGOOD_TK - 1))
            st_r <= fsss_pkg::ST_ON; // R7 R21
          else
            tk_r <= tk_r + 7'h01;
        end
        fsss_pkg::ST_ON: ;
        default: st_r <= fsss_pkg::ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Regulator enables and live voltage
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_enable_r <= '0;
    end else if (st_r == fsss_pkg::ST_OFF || load_now) begin
      reg_enable_r <= '0;
    end else if (st_r == fsss_pkg::ST_SLOTS) begin
      for (int i = 0; i < fsss_pkg::N_REG; i++) begin
        if (code_of(sh_wide_r, sh_lin_r, i) != 4'h0 &&
            code_of(sh_wide_r, sh_lin_r, i) == slot_r)
          reg_enable_r[i] <= 1'b1; // R5 R20 R4
      end
    end else if (st_r == fsss_pkg::ST_ON && enable_we) begin
      reg_enable_r <= enable_wdata; // R4
    end
  end

  // Live voltage follows shadow at start-up, then software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buck1_voltage_live_r <= 5'h00;
    end else if (st_r == fsss_pkg::ST_COPY) begin
      buck1_voltage_live_r <= sh_volt_r; // R1
    end else if (live_volt_we) begin
      buck1_voltage_live_r <= volt_wdata; // R2
    end
  end

  fsss_ramp #(.VW(5)) u_ramp (
    .clock(clock),
    .rst(rst),
    .run(reg_enable_r[0]),
    .rate_sel(sh_ss_r),
    .target(buck1_voltage_live_r),
    .level_r(buck1_ramp_level)
  );

  // ----------------------------------------------------------------
  // Power good, done flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_good_out_r <= 1'b0;
      seq_done_r <= 1'b0;
    end else begin
      power_good_out_r <= (st_r == fsss_pkg::ST_ON); // R7
      seq_done_r <= (st_r == fsss_pkg::ST_ON);
    end
  end
  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      turnon_pin_irq_r <= 1'b0;
    end else if (turn_on) begin
      turnon_pin_irq_r <= 1'b1; // R17
    end else if (irq_clear || st_r == fsss_pkg::ST_OFF) begin
      turnon_pin_irq_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus address configuration
  // ----------------------------------------------------------------
  logic [7:0] addr_cfg;
  assign addr_cfg = bus_addr_we ? bus_addr_wdata : fuse_bus_addr;
  // Written config applies on the cycle after the write strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_address_config_r <= fsss_pkg::BUS_ADDR_RST;
      bus_slave_addr_r <= fsss_pkg::FACTORY_ADDR;
    end else if (bus_addr_we || load_now) begin
      bus_address_config_r <= addr_cfg; // R11
      if (addr_cfg[fsss_pkg::KEEP_FACTORY_BIT])
        bus_slave_addr_r <= fsss_pkg::FACTORY_ADDR; // R12
      else
        bus_slave_addr_r <= {4'h1, addr_cfg[2:0]}; // R10
    end
  end

endmodule

/* dv/fsss_chk_sva.sv */
// Assertions on the ports of the start-up sequencer top.
// Assumes one clock domain with the asynchronous reset rst.
module fsss_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Inputs watched
  input wire logic turnon_pin,
  input wire logic fuse_pin_style,
  input wire logic shadow_volt_we,
  input wire logic live_volt_we,
  input wire logic [4:0] volt_wdata,
  input wire logic bus_addr_we,
  input wire logic [7:0] bus_addr_wdata,
  input wire logic enable_we,
  input wire logic [fsss_pkg::N_REG-1:0] enable_wdata,
  // Outputs watched
  input wire logic [fsss_pkg::N_REG-1:0] reg_enable_r,
  input wire logic [4:0] buck1_voltage_live_r,
  input wire logic [4:0] buck1_ramp_level,
  input wire logic power_good_out_r,
  input wire logic turn_on_pin_level_flag,
  input wire logic [6:0] bus_slave_addr_r,
  input wire logic [7:0] bus_address_config_r,
  input wire logic seq_done_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // One tick of slack: the tick phase at turn-on is free
  localparam int TK = fsss_pkg::TICK_DIV + 1;
  localparam int SLOT_MIN = fsss_pkg::SLOT_SHORT_TK * fsss_pkg::TICK_DIV - TK;
  localparam int PG_MIN = fsss_pkg::PGOOD_TK * fsss_pkg::TICK_DIV - TK;
  localparam int STEP_MIN = fsss_pkg::STEP_FAST_CY - 1;
  logic [7:0] addr_wd_r; // Address write data of the previous cycle
  logic [16:0] en_age_r; // Cycles since enables moved
  logic [7:0] ramp_age_r; // Cycles since the ramp moved

  // Ages saturate so a long quiet spell never wraps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_wd_r <= 8'h00;
      en_age_r <= '1;
      ramp_age_r <= '1;
    end else begin
      addr_wd_r <= bus_addr_wdata;
      if ($changed(reg_enable_r)) begin
        en_age_r <= '0;
      end else if (en_age_r != '1) begin
        en_age_r <= en_age_r + 17'h00001;
      end
      if ($changed(buck1_ramp_level)) begin
        ramp_age_r <= '0;
      end else if (ramp_age_r != '1) begin
        ramp_age_r <= ramp_age_r + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  addr_range_a: assert property (
    bus_slave_addr_r[6:3] == 4'h1) else $error("address out of range");
  addr_write_a: assert property (bus_addr_we |=>
    bus_slave_addr_r == (addr_wd_r[7] ? 7'h08 : {4'h1, addr_wd_r[2:0]}))
    else $error("address not taken");
  cfg_write_a: assert property (
    bus_addr_we |=> bus_address_config_r == addr_wd_r)
    else $error("address register not written");
  pin_flag_a: assert property (
    turn_on_pin_level_flag == $past(turnon_pin, 2))
    else $error("pin flag does not follow pin");
  live_write_a: assert property (
    live_volt_we |=> buck1_voltage_live_r == $past(volt_wdata))
    else $error("live voltage not written");
  shadow_quiet_a: assert property (
    shadow_volt_we && seq_done_r && !live_volt_we
    |=> $stable(buck1_voltage_live_r)) else $error("shadow write moved output");
  sw_enable_a: assert property (
    enable_we && seq_done_r |=> reg_enable_r == $past(enable_wdata))
    else $error("enable write not taken");
  slot_gap_a: assert property (
    $changed(reg_enable_r) && !seq_done_r && reg_enable_r != '0
    && $past(reg_enable_r) != '0 |-> en_age_r >= SLOT_MIN)
    else $error("slot came early");
  pgood_delay_a: assert property (
    $rose(power_good_out_r) |-> en_age_r >= PG_MIN)
    else $error("power good early");
  ramp_step_a: assert property (
    $changed(buck1_ramp_level) && reg_enable_r[0] |->
    ramp_age_r >= STEP_MIN && 5'(buck1_ramp_level
    - $past(buck1_ramp_level)) inside {5'h01, 5'h1f})
    else $error("ramp step wrong");
  level_off_a: assert property (
    $fell(turn_on_pin_level_flag) && !fuse_pin_style && seq_done_r
    |-> ##[1:4] (reg_enable_r == '0 && !power_good_out_r))
    else $error("pin low did not turn off");

  pg_c: cover property ($rose(power_good_out_r));
  keep_c: cover property (bus_addr_we && bus_addr_wdata[7]);
  ramp_c: cover property ($changed(buck1_ramp_level));
endmodule

bind fsss_top fsss_chk fsss_chk_i (.*);

/* dv/fsss_host.sv */
// Host on the serial bus and turn-on pin source, as a model.
// Assumes writes are taken on an edge with the strobe high.
module fsss_host (
  // Clock
  input wire logic clock,
  // Turn-on pin
  output logic turnon_pin,
  // Register writes
  output logic shadow_volt_we,
  output logic live_volt_we,
  output logic [4:0] volt_wdata,
  output logic bus_addr_we,
  output logic [7:0] bus_addr_wdata,
  output logic enable_we,
  output logic [fsss_pkg::N_REG-1:0] enable_wdata,
  output logic irq_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    turnon_pin = 1'b0;
    {shadow_volt_we, live_volt_we, bus_addr_we, enable_we} = 4'h0;
    irq_clear = 1'b0;
    volt_wdata = 5'h00;
    bus_addr_wdata = 8'h00;
    enable_wdata = '0;
  end

  // Level change on the pin
  task automatic pin(input logic v);
    @(posedge clock);
    turnon_pin <= v;
  endtask

  // One write; hold keeps the strobe up for back-to-back bursts
  task automatic wr(input int k, input logic [9:0] d, input bit hold);
    @(posedge clock);
    shadow_volt_we <= (k == 0);
    live_volt_we <= (k == 1);
    bus_addr_we <= (k == 2);
    enable_we <= (k == 3);
    irq_clear <= (k == 4);
    volt_wdata <= d[4:0];
    bus_addr_wdata <= d[7:0];
    enable_wdata <= d;
    if (!hold) begin
      @(posedge clock);
      {shadow_volt_we, live_volt_we, bus_addr_we, enable_we} <= 4'h0;
      irq_clear <= 1'b0;
      // Released data must not look like the last value
      volt_wdata <= ~d[4:0];
      bus_addr_wdata <= ~d[7:0];
      enable_wdata <= ~d;
    end
  endtask
endmodule

/* dv/tb.sv */
// Self-checking bench of the start-up sequencer.
// Assumes the host model drives the pin and all register writes.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct { logic [9:0] v; int lo; int hi; } fsss_note_type;
  localparam int US = fsss_pkg::CLK_HZ / 1_000_000; // Cycles per us
  localparam int TS = fsss_pkg::SLOT_SHORT_US * US; // One slot
  logic clock;
  logic rst = 1'b1;
  logic vin_above_uv = 1'b0;
  logic [fsss_pkg::N_WIDE*3-1:0] fuse_wide_slots = '0;
  logic [fsss_pkg::N_LIN*4-1:0] fuse_lin_slots = '0;
  logic [4:0] fuse_buck1_volt = 5'h00;
  logic [7:0] fuse_bus_addr = 8'h00;
  logic fuse_slot_delay_sel = 1'b0;
  logic fuse_pin_style = 1'b0;
  logic [1:0] fuse_debounce_sel = 2'h0;
  logic fuse_softstart_sel = 1'b0;
  logic turnon_pin, shadow_volt_we, live_volt_we, bus_addr_we;
  logic enable_we, irq_clear, power_good_out_r, turnon_pin_irq_r;
  logic turn_on_pin_level_flag, seq_done_r;
  logic [4:0] volt_wdata, buck1_voltage_live_r, buck1_ramp_level;
  logic [7:0] bus_addr_wdata, bus_address_config_r;
  logic [6:0] bus_slave_addr_r;
  logic [fsss_pkg::N_REG-1:0] enable_wdata, reg_enable_r;
  logic [31:0] seed = 32'hba378a62; // Random state
  fsss_note_type q [4][$]; // Notes: enables, address, volt, pgood
  logic [9:0] cur [4];
  logic [9:0] prv [4];
  time on_t = 0; // Time of the turn-on edge
  int n_errors = 0;
  int checked = 0;

  fsss_top fsss_top_i (.*);
  fsss_host fsss_host_i (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected change; t below zero means any time
  task automatic note(input int k, input logic [9:0] v, input int t);
    fsss_note_type n;
    n.v = v;
    n.lo = (t < 0) ? 0 : t - 1600;
    n.hi = (t < 0) ? 1 << 30 : t + 1600;
    q[k].push_back(n);
  endtask

  // A change with no note left is a mismatch too
  task automatic pop(input int k, input logic [9:0] v);
    fsss_note_type n;
    int d;
    d = int'(($time - on_t) / 20);
    n = '{~v, 0, 0};
    if (q[k].size() > 0) n = q[k].pop_front();
    chk(n.v, v);
    chk(10'h001, 10'(d >= n.lo && d <= n.hi));
  endtask

  task automatic test_done();
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watcher: every change of enables, address, live volt or pgood takes the oldest note
  always @(posedge clock) begin
    cur[0] = reg_enable_r;
    cur[1] = 10'(bus_slave_addr_r);
    cur[2] = 10'(buck1_voltage_live_r);
    cur[3] = 10'(power_good_out_r);
    for (int k = 0; k < 4; k++) begin
      if (!rst && cur[k] !== prv[k]) begin
        pop(k, cur[k]);
      end
    end
    prv = cur;
  end

  // Watchdog well past the longest sequence
  initial begin
    repeat (300000) @(posedge clock);
    n_errors++;
    test_done();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [9:0] e1, e2, e;
    logic [17:0] w;
    logic [15:0] lw;
    logic [31:0] r;
    logic [4:0] v;
    logic [2:0] c, lo3;
    e1 = '0;
    e2 = '0;
    @(posedge clock);
    // Codes 0..2; reg 0 at 2, linear 0 at 1, reg 5 off
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      c = (i == 0) ? 3'h2 : (i == 6) ? 3'h1 : (i == 5) ? 3'h0 : 3'(r % 3);
      e1[i] = (c == 3'h1);
      e2[i] = (c != 3'h0);
      if (i < 6) w[3*i +: 3] = c;
      else lw[4*(i-6) +: 4] = {1'b0, c};
    end
    r = rnd();
    lo3 = r[2:0] | 3'h1;
    v = r[12:8] | 5'h01;
    fuse_wide_slots <= w;
    fuse_lin_slots <= lw;
    fuse_bus_addr <= {1'b0, r[6:3], lo3};
    fuse_buck1_volt <= v;
    fuse_debounce_sel <= r[14:13];
    fuse_softstart_sel <= r[15];
    repeat (15) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(10'h008, 10'(bus_slave_addr_r));
    chk(10'(fsss_pkg::BUS_ADDR_RST), 10'(bus_address_config_r));
    vin_above_uv <= 1'b1;
    note(1, {7'h01, lo3}, -1);
    note(2, 10'(v), -1);
    note(0, e1, TS);
    note(0, e2, 2 * TS);
    note(3, 10'h001, 2 * TS + fsss_pkg::PGOOD_US * US);
    repeat (4) @(posedge clock);
    fsss_host_i.pin(1'b1);
    on_t = $time;
    repeat (20) @(posedge clock);
    chk(10'h001, 10'(turnon_pin_irq_r));
    fsss_host_i.wr(0, 10'(~v), 1'b0);
    fsss_host_i.wr(3, 10'h3ff, 1'b0);
    for (int i = 0; i < 200000 && q[3].size() > 0; i++) @(posedge clock);
    // On: shadow write is silent, live write applies
    fsss_host_i.wr(0, 10'(v ^ 5'h0a), 1'b0);
    v = ~v;
    note(2, 10'(v), -1);
    fsss_host_i.wr(1, 10'(v), 1'b0);
    repeat (6300) @(posedge clock); // Longest ramp at the slow rate
    r = rnd();
    e = r[9:0] | 10'h001;
    if (e == e2) e = e ^ 10'h002;
    note(0, e, -1);
    fsss_host_i.wr(3, e, 1'b0);
    // Every low address, back to back, then the keep bit
    for (int i = 1; i <= 8; i++) begin
      r = rnd();
      note(1, {7'h01, 3'(lo3 + i)}, -1);
      fsss_host_i.wr(2, {3'h0, r[6:3], 3'(lo3 + i)}, 1'b1);
    end
    note(1, 10'h008, -1);
    fsss_host_i.wr(2, {2'h0, 1'b1, r[6:0]}, 1'b0);
    fsss_host_i.wr(4, 10'h000, 1'b0);
    repeat (2) @(posedge clock);
    chk(10'h000, 10'(turnon_pin_irq_r));
    note(0, 10'h000, -1);
    note(3, 10'h000, -1);
    fsss_host_i.pin(1'b0);
    repeat (20) @(posedge clock);
    chk(10'h000, 10'(q[0].size() + q[1].size() + q[2].size() + q[3].size()));
    test_done();
  end
endmodule
